// >>> common/serial_report_pkg.sv
// constants and carriers shared by the serial report and control-input block
`default_nettype none
package serial_report_pkg;
   // ---------------------------------------------------------------
   // timing
   // ---------------------------------------------------------------
   localparam int unsigned CLK_PERIOD_NS = 50;
   localparam int unsigned MS_NS = 1000000;
   localparam int unsigned MS_CYCLES = MS_NS / CLK_PERIOD_NS;
   localparam int unsigned SILENCE_S = 20;
   localparam int unsigned SILENCE_MS = SILENCE_S * 1000;
   localparam logic [16:0] INTERVAL_MAX_MS = 17'd99999;
   // ---------------------------------------------------------------
   // register map (byte addresses)
   // ---------------------------------------------------------------
   localparam logic [7:0] CTRL_OFS = 8'h00;
   localparam logic [7:0] INTERVAL_OFS = 8'h04;
   localparam logic [7:0] SUB_A_OFS = 8'h08;
   localparam logic [7:0] SUB_B_OFS = 8'h0C;
   localparam logic [7:0] SUB_AB_OFS = 8'h10;
   localparam logic [7:0] MULT_OFS = 8'h14;
   localparam logic [7:0] DIV_OFS = 8'h18;
   localparam logic [7:0] OFFSET_OFS = 8'h1C;
   localparam logic [7:0] STATUS_OFS = 8'h20;
   localparam logic [7:0] LIN_BASE_OFS = 8'h80;
   // ---------------------------------------------------------------
   // control and status register fields
   // ---------------------------------------------------------------
   localparam int unsigned SRC_LSB = 0;
   localparam int unsigned LAYOUT_BIT = 5;
   localparam int unsigned POL_BIT = 6;
   localparam int unsigned FUNC_LSB = 7;
   localparam int unsigned UNIT_LSB = 10;
   localparam int unsigned ST_REQRESP_BIT = 0;
   localparam int unsigned ST_CTL_BIT = 1;
   localparam int unsigned ST_PEND_BIT = 2;
   // ---------------------------------------------------------------
   // reset values and codes
   // ---------------------------------------------------------------
   localparam logic [4:0] SRC_RESET = 5'h08;
   localparam logic [6:0] UNIT_RESET = 7'h0B;
   localparam logic [6:0] UNIT_MIN = 7'h0B;
   localparam logic [6:0] UNIT_MAX = 7'h63;
   localparam logic [16:0] INTERVAL_RESET = 17'h00000;
   localparam logic [31:0] MULT_RESET = 32'h00000001;
   localparam logic [31:0] DIV_RESET = 32'h00000001;
   localparam logic [7:0] REQ_END_CHAR = 8'h0D;
   localparam logic [4:0] CODE_RESULT = 5'h08;
   localparam logic [4:0] CODE_FREQ_A = 5'h09;
   localparam logic [4:0] CODE_FREQ_B = 5'h0B;
   localparam logic [4:0] CODE_ANALOG = 5'h0D;

   typedef enum logic [2:0]
   {
      FN_NONE = 3'h0,
      FN_SUB_A = 3'h1,
      FN_SUB_B = 3'h2,
      FN_SUB_AB = 3'h3,
      FN_FRZ_A = 3'h4,
      FN_FRZ_B = 3'h5,
      FN_FRZ_AB = 3'h6,
      FN_SEND = 3'h7
   } ctl_func_e;

   typedef enum logic [1:0]
   {
      MODE_CYCLIC = 2'b01,
      MODE_REQRESP = 2'b10
   } port_mode_e;

   // one report handed to the serialiser
   typedef struct packed
   {
      logic start;
      logic [4:0] code;
      logic with_unit;
      logic [6:0] unit;
      logic [31:0] value;
   } report_s;
endpackage
`default_nettype wire

// >>> rtl/lin_point_mem.sv
// linearisation point store: 16 input and 16 output points, two registered read ports
`default_nettype none
module lin_point_mem
(
   input wire logic clk,
   input wire logic reset_n,
   input wire logic wr_en,
   input wire logic [4:0] wr_addr,
   input wire logic [31:0] wr_data,
   input wire logic [4:0] rd_a_addr,
   output logic [31:0] rd_a_data,
   input wire logic [4:0] rd_b_addr,
   output logic [31:0] rd_b_data
);
   logic [31:0] mem [0:31];
   logic [31:0] rd_a_q;
   logic [31:0] rd_b_q;

   // storage has no reset so it can map onto plain ram
   always_ff @(posedge clk)
   begin
      if (wr_en)
      begin
         mem[wr_addr] <= wr_data;
      end
   end

   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         rd_a_q <= 32'h00000000;
         rd_b_q <= 32'h00000000;
      end
      else
      begin
         rd_a_q <= mem[rd_a_addr];
         rd_b_q <= mem[rd_b_addr];
      end
   end

   assign rd_a_data = rd_a_q;
   assign rd_b_data = rd_b_q;
endmodule
`default_nettype wire

// >>> rtl/serial_report_and_control_input.sv
// serial report scheduling, control input actions and scaling with apb registers
//
// Our own choices: the APB register port and the address map.
`default_nettype none
module serial_report_and_control_input
#(
   parameter int unsigned MS_CYCLES = serial_report_pkg::MS_CYCLES,
   parameter int unsigned SILENCE_MS = serial_report_pkg::SILENCE_MS
)
(
   input wire logic CLK,
   input wire logic RESET_N,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [7:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   input wire logic RX_VALID,
   input wire logic [7:0] RX_CHAR,
   input wire logic TX_READY,
   output serial_report_pkg::report_s REPORT,
   input wire logic CONTROL_PIN,
   input wire logic [31:0] FREQ_A_IN,
   input wire logic [31:0] FREQ_B_IN,
   input wire logic [31:0] COMBINED_IN,
   input wire logic [31:0] ANALOG_IN,
   output logic [31:0] FREQ_A_OUT,
   output logic [31:0] FREQ_B_OUT,
   output logic [31:0] RESULT_OUT,
   input wire logic [4:0] LIN_SEL,
   output logic [31:0] LIN_POINT,
   output logic REQUEST_RESPONSE_MODE
);
   // ---------------------------------------------------------------
   // registers
   // ---------------------------------------------------------------
   logic [4:0] src_q;
   logic layout_q;
   logic pol_q;
   logic [2:0] func_q;
   logic [6:0] unit_q;
   logic [16:0] interval_q;
   logic [31:0] sub_a_q;
   logic [31:0] sub_b_q;
   logic [31:0] sub_ab_q;
   logic [31:0] mult_q;
   logic [31:0] div_q;
   logic [31:0] offset_q;
   logic pready_q;
   logic pslverr_q;
   logic [31:0] prdata_q;
   logic wr_fire;
   logic lin_hit;
   logic [31:0] lin_rd;
   logic [31:0] rd_mux;
   logic rd_ok;

   // writes land only on the completing edge of the access phase
   assign wr_fire = PSEL && PENABLE && pready_q && PWRITE;
   assign lin_hit = PADDR[7] && (PADDR[1:0] == 2'h0);

   function automatic logic unit_ok(input logic [31:0] v);
      logic [6:0] u;
      u = v[serial_report_pkg::UNIT_LSB +: 7];
      unit_ok = (u >= serial_report_pkg::UNIT_MIN) && (u <= serial_report_pkg::UNIT_MAX)
                && ((u % 7'd10) != 7'd0);
   endfunction

   always_ff @(posedge CLK or negedge RESET_N)
   begin
      if (!RESET_N)
      begin
         src_q <= serial_report_pkg::SRC_RESET;
         layout_q <= 1'b0;
         pol_q <= 1'b0;
         func_q <= serial_report_pkg::FN_NONE;
         unit_q <= serial_report_pkg::UNIT_RESET;
      end
      else if (wr_fire && (PADDR == serial_report_pkg::CTRL_OFS))
      begin
         // source codes above 19 are refused, the old code stays
         if (PWDATA[serial_report_pkg::SRC_LSB +: 5] <= 5'h13)
         begin
            src_q <= PWDATA[serial_report_pkg::SRC_LSB +: 5];
         end
         layout_q <= PWDATA[serial_report_pkg::LAYOUT_BIT];
         pol_q <= PWDATA[serial_report_pkg::POL_BIT];
         func_q <= PWDATA[serial_report_pkg::FUNC_LSB +: 3];
         if (unit_ok(PWDATA))
         begin
            unit_q <= PWDATA[serial_report_pkg::UNIT_LSB +: 7];
         end
      end
   end

   always_ff @(posedge CLK or negedge RESET_N)
   begin
      if (!RESET_N)
      begin
         interval_q <= serial_report_pkg::INTERVAL_RESET;
         sub_a_q <= 32'h00000000;
         sub_b_q <= 32'h00000000;
         sub_ab_q <= 32'h00000000;
         mult_q <= serial_report_pkg::MULT_RESET;
         div_q <= serial_report_pkg::DIV_RESET;
         offset_q <= 32'h00000000;
      end
      else if (wr_fire)
      begin
         unique case (PADDR)
            serial_report_pkg::INTERVAL_OFS:
            begin
               // out-of-range intervals clamp to the largest legal period
               if (PWDATA[16:0] > serial_report_pkg::INTERVAL_MAX_MS || PWDATA[31:17] != 15'h0000)
               begin
                  interval_q <= serial_report_pkg::INTERVAL_MAX_MS;
               end
               else
               begin
                  interval_q <= PWDATA[16:0];
               end
            end
            serial_report_pkg::SUB_A_OFS: sub_a_q <= PWDATA;
            serial_report_pkg::SUB_B_OFS: sub_b_q <= PWDATA;
            serial_report_pkg::SUB_AB_OFS: sub_ab_q <= PWDATA;
            serial_report_pkg::MULT_OFS: mult_q <= PWDATA;
            serial_report_pkg::DIV_OFS: div_q <= PWDATA;
            serial_report_pkg::OFFSET_OFS: offset_q <= PWDATA;
            default:
            begin
            end
         endcase
      end
   end

   // ---------------------------------------------------------------
   // linearisation point store
   // ---------------------------------------------------------------
   lin_point_mem u_lin
   (
      .clk(CLK),
      .reset_n(RESET_N),
      .wr_en(wr_fire && lin_hit),
      .wr_addr(PADDR[6:2]),
      .wr_data(PWDATA),
      .rd_a_addr(PADDR[6:2]),
      .rd_a_data(lin_rd),
      .rd_b_addr(LIN_SEL),
      .rd_b_data(LIN_POINT)
   );

   // ---------------------------------------------------------------
   // control input
   // ---------------------------------------------------------------
   logic ctl_q;
   logic ctl_prev_q;
   logic ctl_rise;

   always_ff @(posedge CLK or negedge RESET_N)
   begin
      if (!RESET_N)
      begin
         ctl_q <= 1'b0;
         ctl_prev_q <= 1'b0;
      end
      else
      begin
         ctl_q <= CONTROL_PIN ^ pol_q;
         ctl_prev_q <= ctl_q;
      end
   end

   assign ctl_rise = ctl_q && !ctl_prev_q;

   // live values return as soon as the input drops
   always_ff @(posedge CLK or negedge RESET_N)
   begin
      if (!RESET_N)
      begin
         FREQ_A_OUT <= 32'h00000000;
         FREQ_B_OUT <= 32'h00000000;
      end
      else
      begin
         if (ctl_q && func_q == serial_report_pkg::FN_SUB_A)
         begin
            FREQ_A_OUT <= sub_a_q;
         end
         else if (!(ctl_q && (func_q == serial_report_pkg::FN_FRZ_A || func_q == serial_report_pkg::FN_FRZ_AB)))
         begin
            FREQ_A_OUT <= FREQ_A_IN;
         end
         if (ctl_q && func_q == serial_report_pkg::FN_SUB_B)
         begin
            FREQ_B_OUT <= sub_b_q;
         end
         else if (!(ctl_q && (func_q == serial_report_pkg::FN_FRZ_B || func_q == serial_report_pkg::FN_FRZ_AB)))
         begin
            FREQ_B_OUT <= FREQ_B_IN;
         end
      end
   end

   // ---------------------------------------------------------------
   // final scaling of the combined result
   // ---------------------------------------------------------------
   logic [31:0] comb_sel;
   logic signed [63:0] prod;
   logic signed [63:0] quot;

   always_comb
   begin
      comb_sel = (ctl_q && func_q == serial_report_pkg::FN_SUB_AB) ? sub_ab_q : COMBINED_IN;
      prod = $signed(comb_sel) * $signed(mult_q);
      // a zero divisor passes the product through rather than faulting
      if (div_q == 32'h00000000)
      begin
         quot = prod;
      end
      else
      begin
         quot = prod / $signed({{32{div_q[31]}}, div_q});
      end
   end

   always_ff @(posedge CLK or negedge RESET_N)
   begin
      if (!RESET_N)
      begin
         RESULT_OUT <= 32'h00000000;
      end
      else
      begin
         RESULT_OUT <= quot[31:0] + offset_q;
      end
   end

   // ---------------------------------------------------------------
   // port mode and silence timer
   // ---------------------------------------------------------------
   serial_report_pkg::port_mode_e mode_q;
   logic [31:0] ms_div_q;
   logic ms_tick;
   logic [31:0] silence_q;
   logic [16:0] cyc_q;
   logic cyc_fire;
   logic req_done;

   always_ff @(posedge CLK or negedge RESET_N)
   begin
      if (!RESET_N)
      begin
         ms_div_q <= 32'h00000000;
      end
      else if (ms_div_q == MS_CYCLES - 1)
      begin
         ms_div_q <= 32'h00000000;
      end
      else
      begin
         ms_div_q <= ms_div_q + 32'h00000001;
      end
   end

   assign ms_tick = (ms_div_q == MS_CYCLES - 1);
   assign req_done = RX_VALID && (RX_CHAR == serial_report_pkg::REQ_END_CHAR);

   always_ff @(posedge CLK or negedge RESET_N)
   begin
      if (!RESET_N)
      begin
         mode_q <= serial_report_pkg::MODE_CYCLIC;
         silence_q <= 32'h00000000;
      end
      else if (RX_VALID)
      begin
         mode_q <= serial_report_pkg::MODE_REQRESP;
         silence_q <= 32'h00000000;
      end
      else
      begin
         unique case (mode_q)
            serial_report_pkg::MODE_CYCLIC:
            begin
               silence_q <= 32'h00000000;
            end
            serial_report_pkg::MODE_REQRESP:
            begin
               if (ms_tick)
               begin
                  if (silence_q == SILENCE_MS - 1)
                  begin
                     mode_q <= serial_report_pkg::MODE_CYCLIC;
                     silence_q <= 32'h00000000;
                  end
                  else
                  begin
                     silence_q <= silence_q + 32'h00000001;
                  end
               end
            end
         endcase
      end
   end

   // interval timer restarts whenever cyclic mode is left or disabled
   always_ff @(posedge CLK or negedge RESET_N)
   begin
      if (!RESET_N)
      begin
         cyc_q <= 17'h00000;
      end
      else if (mode_q != serial_report_pkg::MODE_CYCLIC || interval_q == 17'h00000 || RX_VALID)
      begin
         cyc_q <= 17'h00000;
      end
      else if (ms_tick)
      begin
         cyc_q <= cyc_fire ? 17'h00000 : cyc_q + 17'h00001;
      end
   end

   assign cyc_fire = ms_tick && mode_q == serial_report_pkg::MODE_CYCLIC && !RX_VALID
                     && interval_q != 17'h00000 && (cyc_q == interval_q - 17'h00001);

   // ---------------------------------------------------------------
   // report launch
   // ---------------------------------------------------------------
   logic pend_q;
   logic [31:0] value_sel;

   always_comb
   begin
      unique case (src_q)
         serial_report_pkg::CODE_RESULT: value_sel = RESULT_OUT;
         serial_report_pkg::CODE_FREQ_A: value_sel = FREQ_A_OUT;
         serial_report_pkg::CODE_FREQ_B: value_sel = FREQ_B_OUT;
         serial_report_pkg::CODE_ANALOG: value_sel = ANALOG_IN;
         default: value_sel = 32'h00000000;
      endcase
   end

   // a new cause during launch is kept pending, set wins over clear
   always_ff @(posedge CLK or negedge RESET_N)
   begin
      if (!RESET_N)
      begin
         pend_q <= 1'b0;
      end
      else if (cyc_fire || req_done || (ctl_rise && func_q == serial_report_pkg::FN_SEND))
      begin
         pend_q <= 1'b1;
      end
      else if (TX_READY)
      begin
         pend_q <= 1'b0;
      end
   end

   always_ff @(posedge CLK or negedge RESET_N)
   begin
      if (!RESET_N)
      begin
         REPORT <= '0;
      end
      else
      begin
         REPORT.start <= pend_q && TX_READY;
         if (pend_q && TX_READY)
         begin
            REPORT.code <= src_q;
            REPORT.with_unit <= !layout_q;
            REPORT.unit <= unit_q;
            REPORT.value <= value_sel;
         end
      end
   end

   always_ff @(posedge CLK or negedge RESET_N)
   begin
      if (!RESET_N)
      begin
         REQUEST_RESPONSE_MODE <= 1'b0;
      end
      else
      begin
         REQUEST_RESPONSE_MODE <= (mode_q == serial_report_pkg::MODE_REQRESP) || (interval_q == 17'h00000);
      end
   end

   // ---------------------------------------------------------------
   // apb read path, one wait state on every access
   // ---------------------------------------------------------------
   always_comb
   begin
      rd_ok = 1'b1;
      rd_mux = 32'h00000000;
      if (lin_hit)
      begin
         rd_mux = lin_rd;
      end
      else
      begin
         unique case (PADDR)
            serial_report_pkg::CTRL_OFS:
               rd_mux = {15'h0000, unit_q, func_q, pol_q, layout_q, src_q};
            serial_report_pkg::INTERVAL_OFS: rd_mux = {15'h0000, interval_q};
            serial_report_pkg::SUB_A_OFS: rd_mux = sub_a_q;
            serial_report_pkg::SUB_B_OFS: rd_mux = sub_b_q;
            serial_report_pkg::SUB_AB_OFS: rd_mux = sub_ab_q;
            serial_report_pkg::MULT_OFS: rd_mux = mult_q;
            serial_report_pkg::DIV_OFS: rd_mux = div_q;
            serial_report_pkg::OFFSET_OFS: rd_mux = offset_q;
            serial_report_pkg::STATUS_OFS:
               rd_mux = {29'h00000000, pend_q, ctl_q, mode_q == serial_report_pkg::MODE_REQRESP};
            default: rd_ok = 1'b0;
         endcase
      end
   end

   always_ff @(posedge CLK or negedge RESET_N)
   begin
      if (!RESET_N)
      begin
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q <= 32'h00000000;
      end
      else
      begin
         pready_q <= PSEL && PENABLE && !pready_q;
         pslverr_q <= PSEL && PENABLE && !pready_q && !rd_ok;
         if (PSEL && PENABLE && !pready_q && !PWRITE)
         begin
            prdata_q <= rd_mux;
         end
      end
   end

   assign PREADY = pready_q;
   assign PSLVERR = pslverr_q;
   assign PRDATA = prdata_q;
endmodule
`default_nettype wire

// >>> verification/serial_report_properties.sv
// checker on the report and mode ports of the block
`default_nettype none
module serial_report_properties
#(
   parameter int unsigned MS_CYCLES = 4,
   parameter int unsigned SILENCE_MS = 3
)
(
   input wire logic CLK,
   input wire logic RESET_N,
   input wire logic RX_VALID,
   input wire logic [7:0] RX_CHAR,
   input wire logic TX_READY,
   input wire serial_report_pkg::report_s REPORT,
   input wire logic REQUEST_RESPONSE_MODE
);
   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (!RESET_N);
   // a report already on its way may absorb the request, so earlier starts count
   sequence s_req;
      RX_VALID && RX_CHAR == serial_report_pkg::REQ_END_CHAR ##1 TX_READY [*3];
   endsequence
   property p_answer;
      s_req |-> REPORT.start || $past(REPORT.start) || $past(REPORT.start, 2);
   endproperty
   a_answer: assert property (p_answer)
      else $error("request not answered");
   property p_pulse;
      REPORT.start |=> !REPORT.start;
   endproperty
   a_pulse: assert property (p_pulse)
      else $error("start too long");
   property p_paced;
      REPORT.start |-> $past(TX_READY);
   endproperty
   a_paced: assert property (p_paced)
      else $error("start while stalled");
   property p_code;
      REPORT.start |-> REPORT.code <= 5'h13;
   endproperty
   a_code: assert property (p_code)
      else $error("code out of range");
   property p_unit;
      REPORT.start && REPORT.with_unit |-> REPORT.unit inside {[7'h0B:7'h63]} && REPORT.unit % 10 != 0;
   endproperty
   a_unit: assert property (p_unit)
      else $error("bad unit number");
   property p_hold;
      !REPORT.start |-> $stable(REPORT.code) && $stable(REPORT.with_unit);
   endproperty
   a_hold: assert property (p_hold)
      else $error("report fields moved");
   // the mode output is registered from the mode state, so it follows a character by two edges
   property p_leave;
      RX_VALID |-> ##2 REQUEST_RESPONSE_MODE;
   endproperty
   a_leave: assert property (p_leave)
      else $error("mode kept after char");
   property p_stay;
      RX_VALID |-> ##2 REQUEST_RESPONSE_MODE [*8];
   endproperty
   a_stay: assert property (p_stay)
      else $error("silence cut short");
endmodule
bind serial_report_and_control_input serial_report_properties
#(.MS_CYCLES(MS_CYCLES), .SILENCE_MS(SILENCE_MS)) u_props
(
   .CLK(CLK), .RESET_N(RESET_N), .RX_VALID(RX_VALID), .RX_CHAR(RX_CHAR),
   .TX_READY(TX_READY), .REPORT(REPORT), .REQUEST_RESPONSE_MODE(REQUEST_RESPONSE_MODE)
);
`default_nettype wire

// >>> verification/serial_host_model.sv
// host on the serial side: sends characters, takes reports
`default_nettype none
module serial_host_model
(
   input wire logic clk,
   input wire serial_report_pkg::report_s report,
   output logic rx_valid,
   output logic [7:0] rx_char,
   output logic tx_ready
);
   timeunit 1ns;
   timeprecision 1ns;
   int count = 0;
   serial_report_pkg::report_s last;
   initial
   begin
      rx_valid = 1'b0;
      rx_char = 8'h5A;
      tx_ready = 1'b1;
   end
   // an idle char line shows the inverse, so a stale copy is never mistaken for data
   task automatic send_char(input logic [7:0] c);
      @(posedge clk);
      rx_valid <= 1'b1;
      rx_char <= c;
      @(posedge clk);
      rx_valid <= 1'b0;
      rx_char <= ~c;
   endtask
   task automatic set_ready(input logic r);
      @(posedge clk);
      tx_ready <= r;
   endtask
   always @(posedge clk)
   begin
      if (report.start === 1'b1)
      begin
         count <= count + 1;
         last <= report;
      end
   end
endmodule
`default_nettype wire

// >>> verification/tb_serial_report_and_control_input.sv
// bench for the serial report and control-input block
`default_nettype none
module tb_serial_report_and_control_input;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 1'b0;
   logic reset_n = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic pin = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [4:0] lsel = 5'h00;
   logic [31:0] pwdata = 32'h0, fa = 32'h0, fb = 32'h0, cmb = 32'h0;
   logic [31:0] prdata, fa_o, fb_o, res, lpt, q;
   logic pready, pslverr, mode, rxv, txr, err;
   logic [7:0] rxc;
   serial_report_pkg::report_s rep;
   int errors = 0;
   int tests_run = 0;
   always #25 clk = ~clk;
   serial_report_and_control_input #(.MS_CYCLES(4), .SILENCE_MS(3)) DUT
   (
      .CLK(clk), .RESET_N(reset_n), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
      .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
      .RX_VALID(rxv), .RX_CHAR(rxc), .TX_READY(txr), .REPORT(rep), .CONTROL_PIN(pin),
      .FREQ_A_IN(fa), .FREQ_B_IN(fb), .COMBINED_IN(cmb), .ANALOG_IN(~fa), .FREQ_A_OUT(fa_o),
      .FREQ_B_OUT(fb_o), .RESULT_OUT(res), .LIN_SEL(lsel), .LIN_POINT(lpt), .REQUEST_RESPONSE_MODE(mode)
   );
   serial_host_model u_host
   (
      .clk(clk), .report(rep), .rx_valid(rxv), .rx_char(rxc), .tx_ready(txr)
   );
   task automatic tally_and_finish();
      $display("errors %0d, checks %0d", errors, tests_run);
      if (errors == 0 && tests_run > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   task automatic check(input logic [31:0] got, input logic [31:0] exp, input string m);
      tests_run++;
      if (got !== exp)
      begin
         errors++;
         $display("mismatch at %0t: %s got %h want %h", $time, m, got, exp);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      do
      begin
         @(posedge clk);
         n++;
      end
      while (pready !== 1'b1 && n < 16);
      q = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (pready !== 1'b1)
      begin
         errors++;
         $display("mismatch at %0t: bus timeout", $time);
         tally_and_finish();
      end
   endtask
   task automatic t_regs();
      apb(0, 8'h00, 32'h0);
      check(q, 32'h2C08, "ctrl");
      apb(1, 8'h00, 32'h2814);
      apb(0, 8'h00, 32'h0);
      check(q, 32'h2C08, "refused");
      apb(1, 8'h04, 32'h1FFFF);
      apb(0, 8'h04, 32'h0);
      check(q, 32'h1869F, "clamp");
      apb(1, 8'h04, 32'h0);
      apb(0, 8'h40, 32'h0);
      check(err, 32'h1, "unmapped");
      apb(1, 8'h14, 32'h3);
      apb(1, 8'h18, 32'h2);
      apb(1, 8'h1C, 32'h5);
      cmb <= 32'hA;
      cyc(4);
      check(res, 32'h14, "scale");
      apb(1, 8'h14, 32'h1);
      apb(1, 8'h18, 32'h1);
      apb(1, 8'h1C, 32'h0);
      apb(1, 8'hBC, 32'hA5);
      apb(1, 8'hC0, 32'h5A);
      for (int i = 15; i < 17; i++)
      begin
         lsel <= 5'(i);
         cyc(2);
         check(lpt, i == 15 ? 32'hA5 : 32'h5A, "lin pt");
      end
   endtask
   task automatic t_ctl();
      apb(1, 8'h08, 32'h111);
      apb(1, 8'h0C, 32'h222);
      apb(1, 8'h10, 32'h333);
      cmb <= 32'h30;
      for (int f = 0; f < 7; f++)
      begin
         apb(1, 8'h00, 32'h2C08 | 32'(f) << 7);
         fa <= 32'h100 + f;
         fb <= 32'h200 + f;
         cyc(3);
         pin <= 1'b1;
         cyc(3);
         fa <= 32'h400;
         fb <= 32'h500;
         cyc(3);
         check(fa_o, f == 1 ? 32'h111 : f == 4 || f == 6 ? 32'h100 + f : 32'h400, "a");
         check(fb_o, f == 2 ? 32'h222 : f == 5 || f == 6 ? 32'h200 + f : 32'h500, "b");
         check(res, f == 3 ? 32'h333 : 32'h30, "ab");
         pin <= 1'b0;
         cyc(3);
         check(fa_o, 32'h400, "live");
      end
      apb(1, 8'h00, 32'h2CC8);
      cyc(3);
      check(fa_o, 32'h111, "low");
      pin <= 1'b1;
      cyc(3);
      check(fa_o, 32'h400, "high");
   endtask
   task automatic t_req();
      int c;
      apb(1, 8'h00, 32'h2C08);
      c = u_host.count;
      u_host.send_char(8'h41);
      cyc(4);
      check(u_host.count, c, "no req");
      u_host.send_char(serial_report_pkg::REQ_END_CHAR);
      cyc(4);
      check(u_host.count, c + 1, "answer");
      check(u_host.last.code, serial_report_pkg::CODE_RESULT, "code");
      check({u_host.last.with_unit, u_host.last.unit}, 32'h8B, "unit");
      apb(1, 8'h00, 32'h2C28);
      u_host.set_ready(1'b0);
      u_host.send_char(serial_report_pkg::REQ_END_CHAR);
      cyc(6);
      check(u_host.count, c + 1, "stall");
      u_host.set_ready(1'b1);
      cyc(4);
      check(u_host.count, c + 2, "late");
      check(u_host.last.with_unit, 32'h0, "short");
   endtask
   task automatic t_trig();
      int c;
      apb(1, 8'h00, 32'h2F89);
      fa <= 32'h1234;
      pin <= 1'b0;
      cyc(4);
      c = u_host.count;
      for (int i = 1; i < 3; i++)
      begin
         pin <= 1'b1;
         cyc(20);
         check(u_host.count, c + i, "trigger");
         pin <= 1'b0;
         cyc(4);
      end
      check(u_host.last.code, serial_report_pkg::CODE_FREQ_A, "src");
      check(u_host.last.value, 32'h1234, "value");
      // analog source reads the inverted frequency input, so it cannot pass by aliasing input A
      apb(1, 8'h00, 32'h2F8D);
      c = u_host.count;
      pin <= 1'b1;
      cyc(20);
      check(u_host.count, c + 1, "analog trigger");
      check(u_host.last.code, serial_report_pkg::CODE_ANALOG, "analog src");
      check(u_host.last.value, 32'hFFFFEDCB, "analog value");
      pin <= 1'b0;
      cyc(4);
   endtask
   task automatic t_cyc();
      int c;
      apb(1, 8'h04, 32'h5);
      cyc(30);
      check(mode, 32'h0, "cyclic");
      c = u_host.count;
      cyc(200);
      check(u_host.count - c inside {[9:11]}, 32'h1, "rate");
      u_host.send_char(8'h78);
      cyc(2);
      check(mode, 32'h1, "req");
      cyc(1);
      c = u_host.count;
      cyc(8);
      check(u_host.count, c, "quiet");
      cyc(14);
      check(mode, 32'h0, "back");
      apb(1, 8'h04, 32'h0);
      // a report launched just before the write may still be on its way
      cyc(4);
      c = u_host.count;
      cyc(100);
      check(u_host.count, c, "off");
   endtask
   initial
   begin
      cyc(20);
      reset_n <= 1'b1;
      t_regs();
      t_ctl();
      t_req();
      t_trig();
      t_cyc();
      tally_and_finish();
   end
endmodule
`default_nettype wire
